/* File: rtl/wrfpa_pkg.sv */
/*
 * Constants shared by the slave-side arbiter and its engine.
 * Assumes one interconnect clock and a synchronous active-low reset.
 */
package wrfpa_pkg;
	localparam int unsigned NUM_MASTERS = 4;
	localparam int unsigned CHAN_W      = 2;
	localparam int unsigned SHARE_W     = 4;
	localparam int unsigned PRIO_W      = 2;
	// Pipeline stages limit; above zero the grant leaves a flip-flop
	localparam int unsigned PIPE_STAGES = 0;
	localparam logic [SHARE_W-1:0] SHARE_ONE   = 4'h1;
	localparam logic [SHARE_W-1:0] SHARE_RST   = 4'h0;
	localparam logic [CHAN_W-1:0]  CHAN_RST    = 2'h0;
	localparam logic [CHAN_W-1:0]  CHAN_LAST   = 2'h3;
	localparam logic [NUM_MASTERS-1:0] GNT_NONE = 4'h0;

	typedef enum logic [1:0] {
		WRFPA_PICK_RD = 2'b01,
		WRFPA_PICK_WR = 2'b10
	} wrfpa_pick_t;
endpackage : wrfpa_pkg

/* File: rtl/wrfpa_arb_if.sv */
/*
 * Request and grant bundle between the arbiter top and one engine.
 * Assumes both ends share ref_clk_i.
 */
`timescale 1ns/1ps
`default_nettype none
interface wrfpa_arb_if;
	import wrfpa_pkg::*;
	logic [NUM_MASTERS-1:0] req;
	logic                   ready;
	logic [NUM_MASTERS-1:0] gnt;
	logic [CHAN_W-1:0]      chan;
	logic                   valid;
	logic                   xfer;

	modport eng (input req, input ready, output gnt, output chan,
		output valid, output xfer);
	modport top (output req, output ready, input gnt, input chan,
		input valid, input xfer);
endinterface : wrfpa_arb_if
`default_nettype wire

/* File: rtl/wrfpa_engine.sv */
/*
 * One arbitration engine: share-weighted round-robin or fixed priority.
 * Assumes requests come from logic on ref_clk_i.
 */
`timescale 1ns/1ps
`default_nettype none
module wrfpa_engine
	import wrfpa_pkg::*;
(
	input  wire logic                       ref_clk_i,
	input  wire logic                       reset_n_i,
	input  wire logic                       fixed_prio_i,
	input  wire logic                       weighted_i,
	input  wire logic [NUM_MASTERS*SHARE_W-1:0] share_cfg_i,
	input  wire logic [NUM_MASTERS*PRIO_W-1:0]  prio_cfg_i,
	wrfpa_arb_if.eng                        arb
);
	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	logic [CHAN_W-1:0]      own_r;
	logic [SHARE_W-1:0]     rem_r;
	logic                   hold_r;
	logic [NUM_MASTERS-1:0] gnt_r;
	logic [CHAN_W-1:0]      chan_r;
	logic                   valid_r;

	// ------------------------------------------------------------
	// Selection
	// ------------------------------------------------------------
	logic [CHAN_W-1:0]  rr_sel;
	logic [CHAN_W-1:0]  fp_sel;
	logic [CHAN_W-1:0]  sel_c;
	logic [CHAN_W-1:0]  cur_sel;
	logic [SHARE_W-1:0] share_sel;
	logic [SHARE_W-1:0] rem_nxt;
	logic               any_req;
	logic               keep;
	logic               cur_valid;
	logic [NUM_MASTERS-1:0] gnt_c;

	// Next requester after the current owner, idle masters skipped
	always_comb begin
		logic [CHAN_W-1:0] idx;
		idx = own_r;
		rr_sel = own_r;
		for (int k = NUM_MASTERS; k >= 1; k--) begin
			idx = CHAN_W'(own_r + CHAN_W'(k));
			if (arb.req[idx]) begin
				rr_sel = idx; // see RQ5
			end
		end
	end

	// Largest priority value among requesters
	always_comb begin
		logic [PRIO_W-1:0] best;
		best = '0;
		fp_sel = CHAN_RST;
		for (int k = 0; k < NUM_MASTERS; k++) begin
			if (arb.req[k] && (fp_sel == CHAN_RST && !arb.req[0]
				|| prio_cfg_i[k*PRIO_W +: PRIO_W] > best)) begin
				best = prio_cfg_i[k*PRIO_W +: PRIO_W]; // see RQ8
				fp_sel = CHAN_W'(k);
			end
		end
	end

	assign any_req  = |arb.req;
	assign keep     = hold_r && arb.req[own_r] && !fixed_prio_i; // see RQ2
	assign sel_c    = keep ? own_r : (fixed_prio_i ? fp_sel : rr_sel); // see RQ7
	assign gnt_c    = any_req ? (NUM_MASTERS'(1) << sel_c) : GNT_NONE; // see RQ16

	// Grant is combinational or registered
	assign cur_sel   = (PIPE_STAGES > 0) ? chan_r : sel_c; // see RQ15
	assign cur_valid = (PIPE_STAGES > 0) ? valid_r : any_req;
	assign arb.gnt   = (PIPE_STAGES > 0) ? gnt_r : gnt_c;
	assign arb.chan  = cur_sel; // see RQ14
	assign arb.valid = cur_valid;
	assign arb.xfer  = cur_valid && arb.req[cur_sel] && arb.ready; // see RQ13

	// Equal mode gives one share each; zero counts as one
	assign share_sel = (!weighted_i || share_cfg_i[cur_sel*SHARE_W +: SHARE_W]
		== SHARE_RST) ? SHARE_ONE
		: share_cfg_i[cur_sel*SHARE_W +: SHARE_W]; // see RQ1
	assign rem_nxt = (hold_r && cur_sel == own_r)
		? SHARE_W'(rem_r - SHARE_ONE)
		: SHARE_W'(share_sel - SHARE_ONE); // see RQ4

	always_ff @(posedge ref_clk_i) begin
		if (!reset_n_i) begin
			own_r  <= CHAN_LAST;
			rem_r  <= SHARE_RST;
			hold_r <= 1'b0;
		end else if (arb.xfer) begin
			own_r  <= cur_sel;
			rem_r  <= rem_nxt;
			hold_r <= (rem_nxt != SHARE_RST);
		end else begin
			hold_r <= hold_r && arb.req[own_r]; // see RQ3
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (!reset_n_i) begin
			gnt_r   <= GNT_NONE;
			chan_r  <= CHAN_RST;
			valid_r <= 1'b0;
		end else begin
			gnt_r   <= gnt_c;
			chan_r  <= sel_c;
			valid_r <= any_req;
		end
	end

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (!reset_n_i);

	logic [SHARE_W:0]   run_r;
	logic [SHARE_W-1:0] cfg_share;
	logic [SHARE_W-1:0] own_cfg;
	logic [SHARE_W:0]   own_cap;
	logic               fp_lose;

	// Configured shares of the granted master and of the owner
	assign cfg_share = share_cfg_i[cur_sel*SHARE_W +: SHARE_W];
	assign own_cfg   = share_cfg_i[own_r*SHARE_W +: SHARE_W];
	assign own_cap   = (!weighted_i || own_cfg == SHARE_RST)
		? {1'b0, SHARE_ONE} : {1'b0, own_cfg};

	always_ff @(posedge ref_clk_i) begin
		if (!reset_n_i || !arb.xfer) begin
			run_r <= '0;
		end else if (hold_r && cur_sel == own_r) begin
			run_r <= run_r + 1'b1;
		end else begin
			run_r <= 1'b1;
		end
	end

	a_grant_only_req: assert property ( // see RQ5
		(gnt_c & ~arb.req) == GNT_NONE && $onehot0(gnt_c))
		else $error("grant to an idle master");
	a_idle_no_grant: assert property ( // see RQ16
		!any_req |-> gnt_c == GNT_NONE)
		else $error("grant while idle");
	a_idle_hold_pos: assert property ( // see RQ16
		!any_req |=> $stable(own_r))
		else $error("round-robin position moved while idle");
	a_share_limit: assert property ( // see RQ2
		!fixed_prio_i && PIPE_STAGES == 0 |-> run_r <= own_cap)
		else $error("share run too long");
	a_forfeit_drop: assert property ( // see RQ3
		hold_r && !arb.req[own_r] && any_req |-> !gnt_c[own_r])
		else $error("forfeited owner still granted");
	a_reload_full: assert property ( // see RQ4
		arb.xfer && !(hold_r && cur_sel == own_r) && weighted_i
		&& cfg_share != SHARE_RST
		|=> rem_r == SHARE_W'($past(cfg_share) - SHARE_ONE))
		else $error("share count not reloaded");
	a_fixed_best: assert property ( // see RQ8
		fixed_prio_i && any_req |-> !fp_lose)
		else $error("lower priority master granted");

	always_comb begin
		fp_lose = 1'b0;
		for (int k = 0; k < NUM_MASTERS; k++) begin
			if (arb.req[k] && prio_cfg_i[k*PRIO_W +: PRIO_W]
				> prio_cfg_i[sel_c*PRIO_W +: PRIO_W]) begin
				fp_lose = 1'b1;
			end
		end
	end
endmodule : wrfpa_engine
`default_nettype wire

/* File: rtl/wrfpa_arbiter.sv */
/*
 * Per-slave arbiter with separate read and write command arbitration.
 * Assumes all requests and slave readiness come from ref_clk_i logic.
 */
`timescale 1ns/1ps
`default_nettype none
// Operation
// RQ1: Default mode gives every requesting master one transfer in turn.
// RQ2: Weighted mode grants up to its share count of consecutive transfers.
// RQ3: Dropping the request forfeits remaining shares; another requester wins.
// RQ4: A master granted anew gets its full configured share count.
// RQ5: Rotation considers only masters requesting now, skipping idle ones.
// RQ6: Read and write arbitration are independent with common share settings.
// RQ7: Scheme is chosen per slave: round-robin or fixed priority.
// RQ8: Fixed priority grants the requester with the largest priority value.
// RQ9: Masters that lose a fixed priority contest are stalled until served.
// RQ10: Configuration gives each master a distinct priority value.
// RQ11: Single command port: per-master round-robin picks read or write first.
// RQ12: Separate read and write ports feed their own arbiters directly.
// RQ13: A master waits while its slave cannot complete the transfer.
// RQ14: The selected master's channel number steers the command multiplexer.
// RQ15: With pipeline stages above zero the grant is registered.
// RQ16: With no requests there is no grant and the position holds.
module wrfpa_arbiter
	import wrfpa_pkg::*;
(
	input  wire logic                           ref_clk_i,
	input  wire logic                           reset_n_i,
	input  wire logic                           fixed_prio_i,
	input  wire logic                           weighted_i,
	input  wire logic                           single_port_i,
	input  wire logic [NUM_MASTERS*SHARE_W-1:0] share_cfg_i,
	input  wire logic [NUM_MASTERS*PRIO_W-1:0]  prio_cfg_i,
	input  wire logic [NUM_MASTERS-1:0]         rd_req_i,
	input  wire logic [NUM_MASTERS-1:0]         wr_req_i,
	input  wire logic                           rd_ready_i,
	input  wire logic                           wr_ready_i,
	output logic      [NUM_MASTERS-1:0]         rd_gnt_o,
	output logic      [CHAN_W-1:0]              rd_chan_o,
	output logic                                rd_valid_o,
	output logic                                rd_is_wr_o,
	output logic      [NUM_MASTERS-1:0]         wr_gnt_o,
	output logic      [CHAN_W-1:0]              wr_chan_o,
	output logic                                wr_valid_o,
	output logic      [NUM_MASTERS-1:0]         rd_wait_o,
	output logic      [NUM_MASTERS-1:0]         wr_wait_o
);
	// ------------------------------------------------------------
	// Read/write picker per master for a single command port
	// ------------------------------------------------------------
	wrfpa_arb_if rd_if ();
	wrfpa_arb_if wr_if ();

	wrfpa_pick_t             pick_r [NUM_MASTERS];
	logic [NUM_MASTERS-1:0]  take_wr;
	logic [NUM_MASTERS-1:0]  merged_req;
	logic [NUM_MASTERS-1:0]  rd_path_rd;
	logic [NUM_MASTERS-1:0]  rd_path_wr;

	genvar g;
	generate
		for (g = 0; g < NUM_MASTERS; g++) begin : g_pick
			assign take_wr[g] = wr_req_i[g] &&
				(!rd_req_i[g] || pick_r[g] == WRFPA_PICK_WR); // see RQ11
			assign merged_req[g] = rd_req_i[g] || wr_req_i[g];
			assign rd_path_rd[g] = rd_req_i[g] && !take_wr[g];
			assign rd_path_wr[g] = take_wr[g];

			always_ff @(posedge ref_clk_i) begin
				if (!reset_n_i) begin
					pick_r[g] <= WRFPA_PICK_RD;
				end else if (single_port_i && rd_if.xfer
					&& rd_if.chan == CHAN_W'(g)) begin
					case (pick_r[g])
						WRFPA_PICK_RD: pick_r[g] <= WRFPA_PICK_WR;
						WRFPA_PICK_WR: pick_r[g] <= WRFPA_PICK_RD;
						default:       pick_r[g] <= WRFPA_PICK_RD;
					endcase
				end
			end
		end
	endgenerate

	// ------------------------------------------------------------
	// Engines: read port and write port
	// ------------------------------------------------------------
	assign rd_if.req   = single_port_i ? merged_req : rd_req_i; // see RQ11
	assign rd_if.ready = rd_ready_i;
	assign wr_if.req   = single_port_i ? GNT_NONE : wr_req_i; // see RQ12
	assign wr_if.ready = wr_ready_i;

	wrfpa_engine u_rd_eng (
		.ref_clk_i    (ref_clk_i),
		.reset_n_i    (reset_n_i),
		.fixed_prio_i (fixed_prio_i),
		.weighted_i   (weighted_i),
		.share_cfg_i  (share_cfg_i),
		.prio_cfg_i   (prio_cfg_i),
		.arb          (rd_if)
	); // see RQ6

	wrfpa_engine u_wr_eng (
		.ref_clk_i    (ref_clk_i),
		.reset_n_i    (reset_n_i),
		.fixed_prio_i (fixed_prio_i),
		.weighted_i   (weighted_i),
		.share_cfg_i  (share_cfg_i),
		.prio_cfg_i   (prio_cfg_i),
		.arb          (wr_if)
	); // see RQ6

	// ------------------------------------------------------------
	// Outputs and stalls
	// ------------------------------------------------------------
	logic [NUM_MASTERS-1:0] rd_done;
	logic [NUM_MASTERS-1:0] wr_done;
	logic [NUM_MASTERS-1:0] sp_done;

	assign sp_done = rd_if.xfer ? (NUM_MASTERS'(1) << rd_if.chan) : GNT_NONE;
	assign rd_done = single_port_i ? (sp_done & rd_path_rd) : sp_done;
	assign wr_done = single_port_i ? (sp_done & rd_path_wr)
		: (wr_if.xfer ? (NUM_MASTERS'(1) << wr_if.chan) : GNT_NONE);

	assign rd_gnt_o   = rd_if.gnt;
	assign rd_chan_o  = rd_if.chan; // see RQ14
	assign rd_valid_o = rd_if.valid;
	assign rd_is_wr_o = single_port_i && rd_if.valid
		&& rd_path_wr[rd_if.chan];
	assign wr_gnt_o   = wr_if.gnt;
	assign wr_chan_o  = wr_if.chan;
	assign wr_valid_o = wr_if.valid;
	assign rd_wait_o  = rd_req_i & ~rd_done; // see RQ9
	assign wr_wait_o  = wr_req_i & ~wr_done; // see RQ13

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (!reset_n_i);

	sequence s_both_taken(int m);
		single_port_i && rd_req_i[m] && wr_req_i[m] && rd_done[m];
	endsequence

	a_loser_stalled: assert property ( // see RQ13
		rd_valid_o && !rd_ready_i |-> rd_wait_o == rd_req_i)
		else $error("master not held while slave busy");
	a_single_port_wr: assert property ( // see RQ11
		single_port_i |-> wr_gnt_o == GNT_NONE && !wr_valid_o)
		else $error("write engine active on single port");
	a_alt_rd_wr: assert property ( // see RQ11
		s_both_taken(0)
		|=> !(rd_req_i[0] && wr_req_i[0] && rd_done[0]))
		else $error("read taken twice over a waiting write");
	a_fixed_stall: assert property ( // see RQ9
		fixed_prio_i && $countones(rd_req_i) > 1 && !single_port_i
		|-> $countones(rd_wait_o) >= $countones(rd_req_i) - 1)
		else $error("losing masters not stalled");
endmodule : wrfpa_arbiter
`default_nettype wire

/* File: sim/wrfpa_master_model.sv */
/*
 * Masters facing one slave: each requests a loaded count of transfers.
 * Assumes grant from the arbiter and slave ready both come from ref_clk_i logic.
 */
`timescale 1ns/1ps
`default_nettype none
module wrfpa_master_model
	import wrfpa_pkg::*;
(
	input  wire logic                     ref_clk_i,
	input  wire logic                     reset_n_i,
	input  wire logic                     load_i,
	input  wire logic [NUM_MASTERS*4-1:0] cnt_i,
	input  wire logic [NUM_MASTERS-1:0]   gnt_i,
	input  wire logic                     ready_i,
	output logic      [NUM_MASTERS-1:0]   req_o
);
	// ----------------------------------------
	// Transfers left per master
	// ----------------------------------------
	logic [3:0] left_r [NUM_MASTERS];

	always_ff @(posedge ref_clk_i) begin
		for (int k = 0; k < NUM_MASTERS; k++) begin
			if (!reset_n_i)
				left_r[k] <= 4'h0;
			else if (load_i)
				left_r[k] <= cnt_i[4*k+:4];
			else if (gnt_i[k] && ready_i && left_r[k] != 4'h0)
				left_r[k] <= left_r[k] - 4'h1;
		end
	end

	// Request stays up until every transfer is served
	always_comb begin
		for (int k = 0; k < NUM_MASTERS; k++)
			req_o[k] = (left_r[k] != 4'h0);
	end
endmodule : wrfpa_master_model
`default_nettype wire

/* File: sim/weighted_rr_fixed_priority_arbiter_tb.sv */
/*
 * Self-checking bench for the per-slave arbiter.
 * Assumes the package widths: four masters, 4-bit shares, 2-bit priority.
 */
`timescale 1ns/1ps
`default_nettype none
module weighted_rr_fixed_priority_arbiter_tb
	import wrfpa_pkg::*;
;
	// ----------------------------------------
	// Signals
	// ----------------------------------------
	logic        ref_clk_i = 1'b0;
	logic        reset_n_i = 1'b0;
	logic        fixed_prio_i = 1'b0;
	logic        weighted_i = 1'b0;
	logic        single_port_i = 1'b0;
	logic [15:0] share_cfg_i = 16'h0;
	logic [7:0]  prio_cfg_i = 8'h0;
	logic        rd_ready_i = 1'b1;
	logic        wr_ready_i = 1'b1;
	logic        rd_load = 1'b0;
	logic        wr_load = 1'b0;
	logic [15:0] rd_cnt = 16'h0;
	logic [15:0] wr_cnt = 16'h0;
	logic [3:0]  rd_req_i, wr_req_i, rd_gnt_o, wr_gnt_o;
	logic [3:0]  rd_wait_o, wr_wait_o, rd_srv, wr_srv;
	logic [1:0]  rd_chan_o, wr_chan_o;
	logic        rd_valid_o, wr_valid_o, rd_is_wr_o, wr_rdy;
	int          errors = 0;
	int          num_checks = 0;

	always #5 ref_clk_i = ~ref_clk_i;

	// Single port: the read engine serves writes too
	assign rd_srv = (single_port_i && rd_is_wr_o) ? 4'h0 : rd_gnt_o;
	assign wr_srv = !single_port_i ? wr_gnt_o :
		(rd_is_wr_o ? rd_gnt_o : 4'h0);
	assign wr_rdy = single_port_i ? rd_ready_i : wr_ready_i;

	wrfpa_arbiter dut (.ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i),
		.fixed_prio_i(fixed_prio_i), .weighted_i(weighted_i),
		.single_port_i(single_port_i), .share_cfg_i(share_cfg_i),
		.prio_cfg_i(prio_cfg_i), .rd_req_i(rd_req_i), .wr_req_i(wr_req_i),
		.rd_ready_i(rd_ready_i), .wr_ready_i(wr_ready_i),
		.rd_gnt_o(rd_gnt_o), .rd_chan_o(rd_chan_o), .rd_valid_o(rd_valid_o),
		.rd_is_wr_o(rd_is_wr_o), .wr_gnt_o(wr_gnt_o), .wr_chan_o(wr_chan_o),
		.wr_valid_o(wr_valid_o), .rd_wait_o(rd_wait_o),
		.wr_wait_o(wr_wait_o));
	wrfpa_master_model rd_m (.ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i),
		.load_i(rd_load), .cnt_i(rd_cnt), .gnt_i(rd_srv),
		.ready_i(rd_ready_i), .req_o(rd_req_i));
	wrfpa_master_model wr_m (.ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i),
		.load_i(wr_load), .cnt_i(wr_cnt), .gnt_i(wr_srv),
		.ready_i(wr_rdy), .req_o(wr_req_i));

	// ----------------------------------------
	// Shared tasks
	// ----------------------------------------
	task chk(input logic [3:0] got, input logic [3:0] exp);
		num_checks++;
		if (got !== exp) begin
			errors++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task start(input logic fx, input logic wt, input logic sp,
		input logic [15:0] sh, input logic [7:0] pr);
		@(posedge ref_clk_i);
		reset_n_i <= 1'b0;
		fixed_prio_i <= fx;
		weighted_i <= wt;
		single_port_i <= sp;
		share_cfg_i <= sh;
		prio_cfg_i <= pr;
		repeat (10) @(posedge ref_clk_i);
		reset_n_i <= 1'b1;
	endtask : start

	task load(input logic [15:0] rc, input logic [15:0] wc);
		@(posedge ref_clk_i);
		rd_cnt <= rc;
		wr_cnt <= wc;
		rd_load <= 1'b1;
		wr_load <= 1'b1;
		@(posedge ref_clk_i);
		rd_load <= 1'b0;
		wr_load <= 1'b0;
	endtask : load

	// Expected channel i sits in seq[2i+1:2i]
	task chk_seq(input int n, input logic [15:0] seq);
		for (int i = 0; i < n; i++) begin
			@(negedge ref_clk_i);
			chk(rd_gnt_o, 4'h1 << seq[2*i+:2]);
			chk({2'b00, rd_chan_o}, {2'b00, seq[2*i+:2]});
		end
	endtask : chk_seq

	task idle_chk;
		@(negedge ref_clk_i);
		chk(rd_gnt_o, 4'h0);
		chk({3'b000, rd_valid_o}, 4'h0);
		chk({3'b000, wr_valid_o}, 4'h0);
	endtask : idle_chk

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task t_equal;
		start(1'b0, 1'b0, 1'b0, 16'h0, 8'h0);
		wr_ready_i <= 1'b0;
		load(16'h2012, 16'h0100);
		@(negedge ref_clk_i);
		chk(rd_gnt_o, 4'h1);
		chk(wr_gnt_o, 4'h4);
		chk({2'b00, wr_chan_o}, 4'h2);
		chk({3'b000, wr_valid_o}, 4'h1);
		chk(wr_wait_o, 4'h4);
		@(posedge ref_clk_i);
		wr_ready_i <= 1'b1;
		chk_seq(4, 16'h00cd);
		idle_chk();
	endtask : t_equal

	task t_weight;
		start(1'b0, 1'b1, 1'b0, 16'h0043, 8'h0);
		load(16'h0044, 16'h0);
		chk_seq(8, 16'h1540);
		idle_chk();
	endtask : t_weight

	task t_forfeit;
		start(1'b0, 1'b1, 1'b0, 16'h0033, 8'h0);
		load(16'h0041, 16'h0);
		chk_seq(5, 16'h0154);
		idle_chk();
	endtask : t_forfeit

	task t_fixed;
		start(1'b1, 1'b0, 1'b0, 16'h0, 8'h2d);
		rd_ready_i <= 1'b0;
		load(16'h0111, 16'h0);
		@(negedge ref_clk_i);
		chk(rd_gnt_o, 4'h2);
		chk(rd_wait_o, 4'h7);
		@(posedge ref_clk_i);
		rd_ready_i <= 1'b1;
		@(negedge ref_clk_i);
		chk(rd_wait_o, 4'h5);
		chk_seq(2, 16'h0002);
		idle_chk();
	endtask : t_fixed

	task t_single;
		start(1'b0, 1'b0, 1'b1, 16'h0, 8'h0);
		load(16'h0002, 16'h0002);
		for (int i = 0; i < 4; i++) begin
			@(negedge ref_clk_i);
			chk(rd_gnt_o, 4'h1);
			chk({3'b000, rd_is_wr_o}, {3'b000, i[0]});
			chk(wr_gnt_o, 4'h0);
		end
		idle_chk();
	endtask : t_single

	task give_verdict;
		$display("checks %0d errors %0d", num_checks, errors);
		if (errors == 0 && num_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : give_verdict

	initial begin
		#20000;
		errors++;
		give_verdict();
	end

	initial begin
		t_equal();
		t_weight();
		t_forfeit();
		t_fixed();
		t_single();
		give_verdict();
	end
endmodule : weighted_rr_fixed_priority_arbiter_tb
`default_nettype wire
